//--- hw/scc_pkg.sv
// constants shared by the system clock source control block
// assumes a 100 MHz register clock and a word-aligned Avalon-MM slave
package scc_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [3:0] REG_SLEEP = 4'h0;
   localparam logic [3:0] REG_CLOCK = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CRYSTAL_STABLE_FLAG_BIT = 6;
   localparam int RC_STB_BIT = 5;
   localparam int PD_BIT = 2;
   localparam int SLOW_SEL_BIT = 7;
   localparam int SRC_SEL_BIT = 6;
   localparam int CAL_BUSY_BIT = 28;
   localparam int SLOW_CAL_BIT = 29;
   localparam int SWITCH_BIT = 30;
   localparam int SLEEP_REQ_BIT = 31;

   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic PD_RESET = 1'h1;
   localparam logic SRC_RESET = 1'h1;
   localparam logic SLOW_SEL_RESET = 1'h1;
   localparam logic [2:0] DIV_RESET = 3'h1;
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_DEEP = 2'h2;
   localparam logic SRC_CRYSTAL = 1'h0;
   localparam logic SRC_RC = 1'h1;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int SWITCH_GAP_NS = 30;
   localparam int SWITCH_GAP_CYCLES =
      (SWITCH_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   typedef enum logic [1:0] {
      SW_STEADY = 2'h0,
      SW_WAIT = 2'h1,
      SW_GAP = 2'h3
   } scc_switch_state_type;
endpackage : scc_pkg

//--- hw/scc_sync2.sv
// two-stage synchroniser for levels arriving from the oscillators and the wake input
// assumes inputs are slow levels, held far longer than two clocks
`timescale 1ns/10ps
module scc_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clock, // register clock
   input wire logic sys_rst, // async reset, active high
   input wire logic [WIDTH-1:0] asyncIn, // levels from another domain
   output logic [WIDTH-1:0] syncOut // resynchronised levels
);
   logic [WIDTH-1:0] firstStage;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         firstStage <= '0;
         syncOut <= '0;
      end else begin
         firstStage <= asyncIn;
         syncOut <= firstStage;
      end
   end
endmodule : scc_sync2

//--- hw/scc_clock_control.sv
// system clock source control: source switch, powerdown, calibration
// assumes oscillator flags are asynchronous levels; the clock mux outside
// obeys the two gate enables, which are never high together
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module scc_clock_control #(
   parameter bit USB_VARIANT = 1'b0
) (
   input wire logic clock, // 100 MHz register clock
   input wire logic sys_rst, // async reset, active high
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic crystalStableIn, // crystal stable, async
   input wire logic fastRcStableIn, // fast RC stable, async
   input wire logic rcCalDoneIn, // fast RC calibration done, async
   input wire logic slowRcCalBusyIn, // slow RC calibrating, async
   input wire logic wakeIn, // wake event level, async
   output logic crystalPowerOn, // fast crystal oscillator enable
   output logic fastRcPowerOn, // fast RC oscillator enable
   output logic crystalGateEn, // mux leg: crystal drives sysclk
   output logic fastRcGateEn, // mux leg: fast RC drives sysclk
   output logic sysclkHalveCrystal, // derive sysclk at half crystal
   output logic slowClockUseCrystal, // slow clock from 32.768 kHz crystal
   output logic [2:0] sysclkDivider, // system clock divider setting
   output logic rcCalStart, // one-cycle start of fast RC calibration
   output logic rcCalRestore, // one-cycle restore of default RC trim
   output logic sleepEnter, // one-cycle sleep entry strobe
   output logic [1:0] sleepState // power state being held
);
   // ****************************************
   // synchronised inputs
   // ****************************************
   logic [4:0] syncLevels;
   logic crystalStable, rcStable, calDone, slowCalBusy, wake;
   logic calDoneLast, wakeLast;

   scc_sync2 #(.WIDTH(5)) syncInputs (
      .clock(clock),
      .sys_rst(sys_rst),
      .asyncIn({crystalStableIn, fastRcStableIn, rcCalDoneIn,
                slowRcCalBusyIn, wakeIn}),
      .syncOut(syncLevels)
   );

   assign {crystalStable, rcStable, calDone, slowCalBusy, wake} = syncLevels;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         calDoneLast <= 1'b0;
         wakeLast <= 1'b0;
      end else begin
         calDoneLast <= calDone;
         wakeLast <= wake;
      end
   end

   wire calDoneRise = calDone && !calDoneLast;
   wire wakeRise = wake && !wakeLast;

   // ****************************************
   // rate table
   // ****************************************
   function automatic logic [9:0] maxRate(input logic [2:0] div,
                                          input logic gfsk);
      logic [9:0] rate;
      rate = 10'h0;
      case (div)
         3'h0, 3'h1, 3'h2, 3'h3: rate = gfsk ? 10'hfa : 10'h1f4;
         3'h4: rate = gfsk ? 10'hfa : 10'h190;
         3'h5: rate = 10'hc8;
         3'h6: rate = 10'h64;
         default: rate = 10'h32;
      endcase
      return rate;
   endfunction : maxRate

   // ****************************************
   // bus slave: one wait state per access
   // ****************************************
   logic busAck;
   wire busReq = avs_read || avs_write;
   wire wrStrobe = avs_write && busAck && avs_byteenable[0];
   wire wrSleep = wrStrobe && avs_address == scc_pkg::REG_SLEEP;
   wire wrClock = wrStrobe && avs_address == scc_pkg::REG_CLOCK;

   assign avs_waitrequest = busReq && !busAck;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         busAck <= 1'b0;
      end else begin
         busAck <= busReq && !busAck;
      end
   end

   // ****************************************
   // control state
   // ****************************************
   scc_pkg::scc_switch_state_type switchState;
   logic selReq, curSrc, powerDown, pdPending;
   logic calPending, calBusy, sleepPending, sleptOnCrystal;
   logic [1:0] modeField;
   logic [1:0] gapCount;

   wire newSel = avs_writedata[scc_pkg::SRC_SEL_BIT];
   wire selToggle = wrClock && newSel != selReq;
   wire anyCal = calBusy || slowCalBusy;
   wire targetStable = selReq ? rcStable : crystalStable;
   wire rcSwitchFree = selReq == scc_pkg::SRC_CRYSTAL || !anyCal;
   // a queued calibration on crystal also holds sleep off
   wire sleepGo = sleepPending && !calBusy
                  && !(calPending && curSrc == scc_pkg::SRC_CRYSTAL)
                  && switchState == scc_pkg::SW_STEADY;

   // source switch sequencer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         switchState <= scc_pkg::SW_STEADY;
         curSrc <= scc_pkg::SRC_RESET;
         gapCount <= 2'h0;
      end else begin
         case (switchState)
            scc_pkg::SW_STEADY: begin
               if (selReq != curSrc)
                  switchState <= scc_pkg::SW_WAIT;
            end
            scc_pkg::SW_WAIT: begin
               if (selReq == curSrc) begin
                  switchState <= scc_pkg::SW_STEADY;
               end else if (targetStable && rcSwitchFree) begin
                  switchState <= scc_pkg::SW_GAP;
                  gapCount <= 2'(scc_pkg::SWITCH_GAP_CYCLES - 1);
               end
            end
            scc_pkg::SW_GAP: begin
               if (gapCount == 2'h0) begin
                  curSrc <= selReq;
                  switchState <= scc_pkg::SW_STEADY;
               end else begin
                  gapCount <= gapCount - 2'h1;
               end
            end
            default: switchState <= scc_pkg::SW_STEADY;
         endcase
      end
   end

   // clock control register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         selReq <= scc_pkg::SRC_RESET;
         slowClockUseCrystal <= !scc_pkg::SLOW_SEL_RESET;
         sysclkDivider <= scc_pkg::DIV_RESET;
      end else if (wrClock) begin
         selReq <= newSel;
         slowClockUseCrystal <=
            !avs_writedata[scc_pkg::SLOW_SEL_BIT];
         sysclkDivider <= avs_writedata[2:0];
      end
   end

   // powerdown bit; a set during calibration waits for its end
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         powerDown <= scc_pkg::PD_RESET;
         pdPending <= 1'b0;
      end else if (selToggle) begin
         powerDown <= 1'b0;
         pdPending <= 1'b0;
      end else if (wrSleep) begin
         if (avs_writedata[scc_pkg::PD_BIT] && anyCal) begin
            pdPending <= 1'b1;
         end else begin
            powerDown <= avs_writedata[scc_pkg::PD_BIT];
            pdPending <= 1'b0;
         end
      end else if (pdPending && !anyCal) begin
         powerDown <= 1'b1;
         pdPending <= 1'b0;
      end
   end

   // fast RC calibration: one run per crystal selection or per wake from sleep entered on crystal
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         calPending <= 1'b0;
         calBusy <= 1'b0;
         rcCalStart <= 1'b0;
      end else begin
         rcCalStart <= 1'b0;
         if (calBusy && calDoneRise)
            calBusy <= 1'b0;
         if (selToggle && newSel == scc_pkg::SRC_CRYSTAL) begin
            calPending <= 1'b1;
         end else if (wakeRise && sleptOnCrystal
                      && sleepState != scc_pkg::MODE_ACTIVE) begin
            calPending <= 1'b1;
         end else if (calPending && !calBusy && crystalStable
                      && curSrc == scc_pkg::SRC_CRYSTAL
                      && switchState == scc_pkg::SW_STEADY) begin
            calPending <= 1'b0;
            calBusy <= 1'b1;
            rcCalStart <= 1'b1;
         end
      end
   end

   // power mode field and sleep sequencing
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         modeField <= scc_pkg::MODE_ACTIVE;
         sleepPending <= 1'b0;
         sleepEnter <= 1'b0;
         sleepState <= scc_pkg::MODE_ACTIVE;
         sleptOnCrystal <= 1'b0;
         rcCalRestore <= 1'b0;
      end else begin
         sleepEnter <= 1'b0;
         rcCalRestore <= 1'b0;
         if (sleepGo) begin
            modeField <= scc_pkg::MODE_ACTIVE;
            sleepPending <= 1'b0;
            sleepEnter <= 1'b1;
            sleepState <= modeField;
            sleptOnCrystal <= curSrc == scc_pkg::SRC_CRYSTAL;
         end else if (wrSleep) begin
            modeField <= avs_writedata[1:0];
            sleepPending <= avs_writedata[1:0] != scc_pkg::MODE_ACTIVE
                            && sleepState == scc_pkg::MODE_ACTIVE;
         end
         if (wakeRise && sleepState != scc_pkg::MODE_ACTIVE) begin
            sleepState <= scc_pkg::MODE_ACTIVE;
            rcCalRestore <= sleepState >= scc_pkg::MODE_DEEP;
         end
      end
   end

   // ****************************************
   // oscillator enables and mux legs
   // ****************************************
   // the target leg opens only after the gap, so no runt pulse escapes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         crystalPowerOn <= 1'b1;
         fastRcPowerOn <= 1'b1;
         crystalGateEn <= 1'b0;
         fastRcGateEn <= 1'b0;
         sysclkHalveCrystal <= 1'b0;
      end else begin
         crystalPowerOn <= !powerDown || curSrc == scc_pkg::SRC_CRYSTAL
                           || selReq == scc_pkg::SRC_CRYSTAL;
         fastRcPowerOn <= !powerDown || curSrc == scc_pkg::SRC_RC
                          || selReq == scc_pkg::SRC_RC
                          || calBusy;
         crystalGateEn <= switchState != scc_pkg::SW_GAP
                          && curSrc == scc_pkg::SRC_CRYSTAL;
         fastRcGateEn <= switchState != scc_pkg::SW_GAP
                         && curSrc == scc_pkg::SRC_RC;
         sysclkHalveCrystal <= USB_VARIANT;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !busAck) begin
         avs_readdata <= 32'h0;
         case (avs_address)
            scc_pkg::REG_SLEEP: begin
               avs_readdata[scc_pkg::CRYSTAL_STABLE_FLAG_BIT] <=
                  crystalStable;
               avs_readdata[scc_pkg::RC_STB_BIT] <= rcStable;
               avs_readdata[scc_pkg::PD_BIT] <= powerDown;
               avs_readdata[1:0] <= modeField;
            end
            scc_pkg::REG_CLOCK: begin
               avs_readdata[scc_pkg::SLOW_SEL_BIT] <= !slowClockUseCrystal;
               avs_readdata[scc_pkg::SRC_SEL_BIT] <= curSrc;
               avs_readdata[2:0] <= sysclkDivider;
            end
            scc_pkg::REG_STATUS: begin
               avs_readdata[9:0] <= maxRate(sysclkDivider, 1'b0);
               avs_readdata[25:16] <= maxRate(sysclkDivider, 1'b1);
               avs_readdata[scc_pkg::CAL_BUSY_BIT] <= calBusy;
               avs_readdata[scc_pkg::SLOW_CAL_BIT] <= slowCalBusy;
               avs_readdata[scc_pkg::SWITCH_BIT] <= selReq != curSrc;
               avs_readdata[scc_pkg::SLEEP_REQ_BIT] <= sleepPending;
            end
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_modeCleared;
      @(posedge clock) disable iff (sys_rst)
      sleepEnter |-> modeField == scc_pkg::MODE_ACTIVE
                     && sleepState != scc_pkg::MODE_ACTIVE;
   endproperty
   a_modeCleared: assert property (p_modeCleared)
      else $error("mode field not cleared at sleep entry");

   property p_unselectedOff;
      @(posedge clock) disable iff (sys_rst)
      (powerDown && !calBusy && selReq == curSrc)
         ##1 (powerDown && !calBusy && selReq == curSrc)
      |-> (curSrc ? !crystalPowerOn : !fastRcPowerOn);
   endproperty
   a_unselectedOff: assert property (p_unselectedOff)
      else $error("unselected oscillator left powered");

   property p_waitStable;
      @(posedge clock) disable iff (sys_rst)
      (switchState == scc_pkg::SW_WAIT && !targetStable)
      |=> switchState != scc_pkg::SW_GAP;
   endproperty
   a_waitStable: assert property (p_waitStable)
      else $error("switch began before target stable");

   property p_calBlocksRc;
      @(posedge clock) disable iff (sys_rst)
      (switchState == scc_pkg::SW_WAIT && selReq && anyCal)
      |=> switchState != scc_pkg::SW_GAP;
   endproperty
   a_calBlocksRc: assert property (p_calBlocksRc)
      else $error("switch to RC during calibration");

   property p_toggleClears;
      @(posedge clock) disable iff (sys_rst)
      selToggle |=> !powerDown ##1 (selReq == $past(newSel, 2));
   endproperty
   a_toggleClears: assert property (p_toggleClears)
      else $error("source toggle did not clear powerdown");

   property p_crystalCal;
      @(posedge clock) disable iff (sys_rst)
      (selToggle && newSel == scc_pkg::SRC_CRYSTAL)
      |=> calPending || calBusy;
   endproperty
   a_crystalCal: assert property (p_crystalCal)
      else $error("crystal select did not queue calibration");

   property p_noSleepInCal;
      @(posedge clock) disable iff (sys_rst)
      $past(calBusy) |-> !sleepEnter;
   endproperty
   a_noSleepInCal: assert property (p_noSleepInCal)
      else $error("sleep entered during calibration");

   property p_pdDeferred;
      @(posedge clock) disable iff (sys_rst)
      (wrSleep && !selToggle && avs_writedata[scc_pkg::PD_BIT] && anyCal
       && !powerDown) |=> !powerDown && pdPending;
   endproperty
   a_pdDeferred: assert property (p_pdDeferred)
      else $error("powerdown set during calibration");

   property p_breakBeforeMake;
      @(posedge clock) disable iff (sys_rst)
      !(crystalGateEn && fastRcGateEn);
   endproperty
   a_breakBeforeMake: assert property (p_breakBeforeMake)
      else $error("both mux legs open");

   property p_deepRestore;
      @(posedge clock) disable iff (sys_rst)
      (wakeRise && sleepState >= scc_pkg::MODE_DEEP) |=> rcCalRestore;
   endproperty
   a_deepRestore: assert property (p_deepRestore)
      else $error("no calibration restore after deep wake");

   property p_busAnswer;
      @(posedge clock) disable iff (sys_rst)
      busReq |-> ##[0:1] !avs_waitrequest;
   endproperty
   a_busAnswer: assert property (p_busAnswer)
      else $error("bus answer late");

   c_switchDone: cover property (@(posedge clock) disable iff (sys_rst)
      switchState == scc_pkg::SW_GAP ##1 switchState == scc_pkg::SW_STEADY);
   c_sleepEntry: cover property (@(posedge clock) disable iff (sys_rst)
      sleepEnter);
   c_calStart: cover property (@(posedge clock) disable iff (sys_rst)
      rcCalStart);
   c_deferredPd: cover property (@(posedge clock) disable iff (sys_rst)
      pdPending ##1 !pdPending && powerDown);
endmodule : scc_clock_control

//--- test/scc_osc_model.sv
// behavioural fast crystal, fast RC and RC calibration engine
// assumes it shares the register clock; flags drop at once on power-off
`timescale 1ns/10ps
module scc_osc_model #(
   parameter int XO_CYC = 12,
   parameter int RC_CYC = 4,
   parameter int CAL_CYC = 30
) (
   input wire logic clock, // register clock
   input wire logic crystalPowerOn, // crystal enable
   input wire logic fastRcPowerOn, // fast RC enable
   input wire logic rcCalStart, // calibration start strobe
   output logic crystalStableIn, // crystal settled
   output logic fastRcStableIn, // fast RC settled
   output logic rcCalDoneIn // calibration finished pulse
);
   int xoCount = 0;
   int rcCount = 0;
   int calCount = 0;
   // settling restarts from zero after every power-off
   always @(posedge clock) begin
      xoCount <= !crystalPowerOn ? 0 : xoCount + (xoCount < XO_CYC);
      rcCount <= !fastRcPowerOn ? 0 : rcCount + (rcCount < RC_CYC);
      if (rcCalStart) calCount <= CAL_CYC;
      else if (calCount > 0) calCount <= calCount - 1;
      rcCalDoneIn <= (calCount == 1);
   end
   assign crystalStableIn = crystalPowerOn && xoCount >= XO_CYC;
   assign fastRcStableIn = fastRcPowerOn && rcCount >= RC_CYC;
endmodule : scc_osc_model

//--- test/tb.sv
// self-checking bench for the system clock source control block
// assumes the oscillator model on the far side, firmware role played here
`timescale 1ns/10ps
module tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, wakeIn = 1'b0;
   logic crystalStableIn, fastRcStableIn, rcCalDoneIn, rcCalRestore;
   logic crystalPowerOn, fastRcPowerOn, crystalGateEn, fastRcGateEn;
   logic sysclkHalveCrystal, slowClockUseCrystal, rcCalStart, sleepEnter;
   logic [2:0] sysclkDivider;
   logic [1:0] sleepState;
   logic slowCal = 1'b0;
   logic [3:0] byteEn = 4'hf;
   int num_errors = 0;
   int samples_checked = 0;
   int calStarts = 0;
   int restores = 0;
   int enters = 0;
   // ****************
   // rows: divider in, rate limits out
   // ****************
   logic [9:0] fskTab [8] = '{10'h1f4, 10'h1f4, 10'h1f4, 10'h1f4,
      10'h190, 10'h0c8, 10'h064, 10'h032};
   logic [9:0] askTab [8] = '{10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa,
      10'h0fa, 10'h0c8, 10'h064, 10'h032};
   always #5 clock = ~clock;
   scc_clock_control #(.USB_VARIANT(1'b0)) u_dut (.clock(clock),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(byteEn), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .crystalStableIn(crystalStableIn),
      .fastRcStableIn(fastRcStableIn), .rcCalDoneIn(rcCalDoneIn),
      .slowRcCalBusyIn(slowCal), .wakeIn(wakeIn),
      .crystalPowerOn(crystalPowerOn), .fastRcPowerOn(fastRcPowerOn),
      .crystalGateEn(crystalGateEn), .fastRcGateEn(fastRcGateEn),
      .sysclkHalveCrystal(sysclkHalveCrystal),
      .slowClockUseCrystal(slowClockUseCrystal),
      .sysclkDivider(sysclkDivider), .rcCalStart(rcCalStart),
      .rcCalRestore(rcCalRestore), .sleepEnter(sleepEnter),
      .sleepState(sleepState));
   scc_osc_model u_osc (.clock(clock), .crystalPowerOn(crystalPowerOn),
      .fastRcPowerOn(fastRcPowerOn), .rcCalStart(rcCalStart),
      .crystalStableIn(crystalStableIn), .fastRcStableIn(fastRcStableIn),
      .rcCalDoneIn(rcCalDoneIn));
   task automatic check(input string name, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task conclude;
      if (num_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // one access; data taken at the edge that sees waitrequest low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         num_errors++;
         conclude;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wait_cnt(ref int c, input int n);
      for (int i = 0; i < 300 && c < n; i++) @(posedge clock);
      if (c < n) begin
         num_errors++;
         conclude;
      end
   endtask : wait_cnt
   always @(posedge clock) begin
      if (rcCalStart === 1'b1) calStarts <= calStarts + 1;
      if (rcCalRestore === 1'b1) restores <= restores + 1;
      if (sleepEnter === 1'b1) enters <= enters + 1;
      if (crystalGateEn === 1'b1 && fastRcGateEn === 1'b1)
         check("both legs", 32'h1, 32'h0);
   end
   initial begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      check("crystalPowerOn", crystalPowerOn, 32'h0);
      check("fastRcGateEn", fastRcGateEn, 32'h1);
      check("halve", sysclkHalveCrystal, 32'h0);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("sleep reset", q & 32'h7, 32'h4);
      bus(1'b0, scc_pkg::REG_CLOCK, 32'h0);
      check("clock reset", q & 32'hc7, 32'hc1);
      bus(1'b0, 4'hc, 32'h0);
      check("unmapped", q, 32'h0);
      for (int r = 0; r < 8; r++) begin
         bus(1'b1, scc_pkg::REG_CLOCK, {24'h0, r[0], 4'h8, r[2:0]});
         bus(1'b0, scc_pkg::REG_STATUS, 32'h0);
         check("fsk", q[9:0], fskTab[r]);
         check("ask", q[25:16], askTab[r]);
         check("divider", sysclkDivider, r[2:0]);
         check("slowsel", slowClockUseCrystal, !r[0]);
      end
      // ****************
      // RC to crystal, calibration, deferred powerdown
      // ****************
      bus(1'b1, scc_pkg::REG_CLOCK, 32'h81);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("pd cleared", q[scc_pkg::PD_BIT], 32'h0);
      check("crystalPowerOn", crystalPowerOn, 32'h1);
      check("early leg", crystalGateEn, 32'h0);
      for (int i = 0; i < 300 && crystalGateEn !== 1'b1; i++)
         @(posedge clock);
      check("rc leg off", fastRcGateEn, 32'h0);
      wait_cnt(calStarts, 1);
      check("cal once", calStarts, 32'h1);
      bus(1'b1, scc_pkg::REG_SLEEP, 32'h4);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("pd deferred", q[scc_pkg::PD_BIT], 32'h0);
      check("rc kept on", fastRcPowerOn, 32'h1);
      for (int i = 0; i < 300 && fastRcPowerOn !== 1'b0; i++)
         @(posedge clock);
      repeat (50) @(posedge clock);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("stable flags", q[6:2], 32'h11);
      check("no repeat", calStarts, 32'h1);
      // ****************
      // deep sleep on crystal, wake, switch back
      // ****************
      bus(1'b1, scc_pkg::REG_SLEEP, 32'h6);
      wait_cnt(enters, 1);
      check("state", sleepState, 32'h2);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("mode cleared", q[1:0], 32'h0);
      wakeIn <= 1'b1;
      repeat (4) @(posedge clock);
      wakeIn <= 1'b0;
      bus(1'b1, scc_pkg::REG_SLEEP, 32'h4);
      wait_cnt(calStarts, 2);
      check("wake cal", calStarts, 32'h2);
      check("restore", restores, 32'h1);
      check("awake", sleepState, 32'h0);
      bus(1'b1, scc_pkg::REG_CLOCK, 32'hc1);
      bus(1'b0, scc_pkg::REG_STATUS, 32'h0);
      check("held", q[scc_pkg::SWITCH_BIT], 32'h1);
      check("cal running", q[scc_pkg::CAL_BUSY_BIT], 32'h1);
      check("rc leg", fastRcGateEn, 32'h0);
      for (int i = 0; i < 300 && fastRcGateEn !== 1'b1; i++)
         @(posedge clock);
      check("xo leg", crystalGateEn, 32'h0);
      bus(1'b0, scc_pkg::REG_STATUS, 32'h0);
      check("cal done", q[scc_pkg::CAL_BUSY_BIT], 32'h0);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("pd toggled", q[scc_pkg::PD_BIT], 32'h0);
      // ****************
      // slow RC calibration defers powerdown; lane 0 off drops a write
      // ****************
      slowCal <= 1'b1;
      bus(1'b1, scc_pkg::REG_SLEEP, 32'h4);
      bus(1'b0, scc_pkg::REG_STATUS, 32'h0);
      check("slow cal", q[scc_pkg::SLOW_CAL_BIT], 32'h1);
      check("pd held", crystalPowerOn, 32'h1);
      slowCal <= 1'b0;
      repeat (6) @(posedge clock);
      check("pd late", crystalPowerOn, 32'h0);
      bus(1'b0, scc_pkg::REG_SLEEP, 32'h0);
      check("pd set", q[scc_pkg::PD_BIT], 32'h1);
      byteEn <= 4'h0;
      bus(1'b1, scc_pkg::REG_CLOCK, 32'hc7);
      byteEn <= 4'hf;
      bus(1'b0, scc_pkg::REG_CLOCK, 32'h0);
      check("lane off", q[2:0], 32'h1);
      conclude;
   end
endmodule : tb
